// File: design/lin_mode_pkg.sv
// constants and types for the lin transceiver mode control block
package lin_mode_pkg;
  // transceiver mode field encodings
  typedef enum logic [1:0] {
    mode_off = 2'h0,
    mode_wake = 2'h1,
    mode_rx_only = 2'h2,
    mode_normal = 2'h3
  } lin_mode_type;
  // chip operating modes
  typedef enum logic [2:0] {
    chip_normal = 3'h0,
    chip_stop = 3'h1,
    chip_sleep = 3'h2,
    chip_restart = 3'h3,
    chip_fail_safe = 3'h4
  } chip_mode_type;
  localparam lin_mode_type MODE_RESET = mode_off;
  localparam int CLK_HZ = 50_000_000;
  // enabling delay in microseconds, multiplied out to cycles
  localparam int EN_TIME_US = 10;
  localparam int EN_CYCLES = (EN_TIME_US * (CLK_HZ / 1_000_000));
  // transmit dominant time-out in microseconds
  localparam int TXD_TO_US = 12000;
  localparam int TXD_TO_CYCLES = (TXD_TO_US * (CLK_HZ / 1_000_000));
  // bus wake filter in microseconds
  localparam int WAKE_FILT_US = 50;
  localparam int WAKE_FILT_CYCLES = (WAKE_FILT_US * (CLK_HZ / 1_000_000));
  // receive noise filter in cycles
  localparam int RX_FILT_CYCLES = 4;
  localparam int CNT_W = 20;
  localparam int FIFO_W = 1;
  localparam int FIFO_D = 8;
endpackage

// File: design/lin_bit_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module lin_bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // handshake terms
  assign push = in_valid && (cnt_r != (AW+1)'(DEPTH));
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];

  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: design/lin_mode_ctrl.sv
// lin transceiver mode control with transmit gating and receive path
`timescale 1ns/10ps
module lin_mode_ctrl (
  input wire logic ref_clk,
  input wire logic reset,
  input wire lin_mode_pkg::chip_mode_type chip_mode,
  input wire logic [1:0] lin_mode_field,
  input wire logic mode_write,
  input wire logic spi_cs_n,
  input wire logic fault_clear,
  input wire logic lin_transmit_input,
  input wire logic bus_level,
  output logic bus_drive_dominant,
  output logic lin_receive_output,
  output logic lin_fault_flag,
  output logic wake_event,
  output logic [1:0] mode_status
);
  import lin_mode_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] txd_sync_r;
  logic [1:0] bus_sync_r;
  logic [1:0] cs_sync_r;
  logic cs_prev_r;
  logic txd_s;
  logic bus_s;
  logic cs_rise;

  // two flops per pin input
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      txd_sync_r <= 2'h3;
      bus_sync_r <= 2'h3;
      cs_sync_r <= 2'h3;
    end else begin
      txd_sync_r <= {txd_sync_r[0], lin_transmit_input};
      bus_sync_r <= {bus_sync_r[0], bus_level};
      cs_sync_r <= {cs_sync_r[0], spi_cs_n};
    end
  end

  // last synchronised chip-select, idle high so no edge after reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cs_prev_r <= 1'b1;
    end else begin
      cs_prev_r <= cs_sync_r[1];
    end
  end
  assign txd_s = txd_sync_r[1];
  assign bus_s = bus_sync_r[1];
  assign cs_rise = cs_sync_r[1] && !cs_prev_r;

  //////////////////////////////////////////////////////////////////////////////
  // mode field capture and commit
  lin_mode_type mode_r;
  lin_mode_type pend_r;
  logic pend_valid_r;
  logic woken_r;
  logic chip_ns;
  logic chip_fs_r;
  logic rearm_r;
  logic fs_prev_r;
  logic fs_entry;
  lin_mode_type req;

  assign chip_ns = (chip_mode == chip_normal) || (chip_mode == chip_stop);
  assign req = pend_r;
  assign fs_entry = (chip_mode == chip_fail_safe) && !fs_prev_r;

  // pending mode value, last write before chip-select release wins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pend_r <= mode_off;
    end else if (mode_write) begin
      pend_r <= lin_mode_type'(lin_mode_field);
    end
  end

  // pending flag held until chip-select release, a new write wins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pend_valid_r <= 1'b0;
    end else if (mode_write) begin
      pend_valid_r <= 1'b1;
    end else if (cs_rise) begin
      pend_valid_r <= 1'b0;
    end
  end

  // mode register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_r <= MODE_RESET;
    end else if (cs_rise && pend_valid_r && req == mode_off) begin
      mode_r <= mode_off;
    end else if (fs_entry) begin
      mode_r <= mode_wake;
    end else if (cs_rise && pend_valid_r) begin
      case (req)
        mode_wake: mode_r <= mode_wake;
        mode_normal: begin
          if (chip_ns) begin
            mode_r <= mode_normal;
          end
        end
        mode_rx_only: begin
          if (chip_ns) begin
            mode_r <= mode_rx_only;
          end
        end
        default: mode_r <= mode_r;
      endcase
    end else if (!chip_ns && (mode_r == mode_normal || mode_r == mode_rx_only)) begin
      mode_r <= mode_wake;
    end
  end

  // stop, sleep or fail-safe seen last cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      chip_fs_r <= 1'b0;
    end else begin
      chip_fs_r <= (chip_mode == chip_stop) || (chip_mode == chip_sleep) || (chip_mode == chip_fail_safe);
    end
  end

  // one-cycle rearm pulse on entry to stop, sleep or fail-safe
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rearm_r <= 1'b0;
    end else begin
      rearm_r <= !chip_fs_r && ((chip_mode == chip_stop) || (chip_mode == chip_sleep) ||
                                (chip_mode == chip_fail_safe));
    end
  end

  // fail-safe seen last cycle; only the entry forces wake, off stays selectable
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fs_prev_r <= 1'b0;
    end else begin
      fs_prev_r <= (chip_mode == chip_fail_safe);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive filter
  logic rx_filt_r;
  logic [2:0] rx_cnt_r;

  // level accepted once stable for the filter time
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rx_filt_r <= 1'b1;
      rx_cnt_r <= '0;
    end else if (bus_s == rx_filt_r) begin
      rx_cnt_r <= '0;
    end else if (rx_cnt_r == 3'(RX_FILT_CYCLES - 1)) begin
      rx_filt_r <= bus_s;
      rx_cnt_r <= '0;
    end else begin
      rx_cnt_r <= rx_cnt_r + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus wake detection, recorded into a fifo of edge samples
  logic [CNT_W-1:0] wk_cnt_r;
  logic wk_long_r;
  logic wk_push;
  logic wk_in_ready;
  logic wk_out_valid;
  logic [FIFO_W-1:0] wk_out_data;

  // dominant long enough then released counts as a wake
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wk_cnt_r <= '0;
      wk_long_r <= 1'b0;
    end else if (mode_r != mode_wake || woken_r) begin
      wk_cnt_r <= '0;
      wk_long_r <= 1'b0;
    end else if (!rx_filt_r) begin
      if (wk_cnt_r == CNT_W'(WAKE_FILT_CYCLES)) begin
        wk_long_r <= 1'b1;
      end else begin
        wk_cnt_r <= wk_cnt_r + 1'b1;
      end
    end else begin
      wk_cnt_r <= '0;
      wk_long_r <= 1'b0;
    end
  end
  assign wk_push = wk_long_r && rx_filt_r && mode_r == mode_wake && !woken_r && wk_in_ready;

  lin_bit_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) wake_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_data(1'b1),
    .in_valid(wk_push),
    .in_ready(wk_in_ready),
    .out_data(wk_out_data),
    .out_valid(wk_out_valid),
    .out_ready(!woken_r)
  );

  // woken state, cleared by leaving wake mode or rearm
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      woken_r <= 1'b0;
    end else if (wk_out_valid && wk_out_data[0] && mode_r == mode_wake) begin
      woken_r <= 1'b1;
    end else if (mode_r != mode_wake || rearm_r) begin
      woken_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // enabling delay and early-low handling
  logic [CNT_W-1:0] en_cnt_r;
  logic en_done_r;
  logic armed_r;

  // delay counter restarts on each entry to normal
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      en_cnt_r <= '0;
      en_done_r <= 1'b0;
    end else if (mode_r != mode_normal) begin
      en_cnt_r <= '0;
      en_done_r <= 1'b0;
    end else if (en_cnt_r == CNT_W'(EN_CYCLES - 1)) begin
      en_done_r <= 1'b1;
    end else begin
      en_cnt_r <= en_cnt_r + 1'b1;
    end
  end

  // transmitter armed only after a high seen past the delay
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      armed_r <= 1'b0;
    end else if (!en_done_r) begin
      armed_r <= 1'b0;
    end else if (txd_s) begin
      armed_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit dominant time-out
  logic [CNT_W-1:0] to_cnt_r;
  logic to_active_r;

  // suspend while low persists, resume when released
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      to_cnt_r <= '0;
      to_active_r <= 1'b0;
    end else if (txd_s || mode_r != mode_normal) begin
      to_cnt_r <= '0;
      to_active_r <= 1'b0;
    end else if (to_cnt_r == CNT_W'(TXD_TO_CYCLES)) begin
      to_active_r <= 1'b1;
    end else begin
      to_cnt_r <= to_cnt_r + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  logic set_fault;
  assign set_fault = to_cnt_r == CNT_W'(TXD_TO_CYCLES) && !txd_s && mode_r == mode_normal;

  // fault flag, set wins over clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lin_fault_flag <= 1'b0;
    end else if (set_fault) begin
      lin_fault_flag <= 1'b1;
    end else if (fault_clear) begin
      lin_fault_flag <= 1'b0;
    end
  end

  // bus driver register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bus_drive_dominant <= 1'b0;
    end else begin
      bus_drive_dominant <= (mode_r == mode_normal) && armed_r && !txd_s && !to_active_r;
    end
  end

  // receive pin register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lin_receive_output <= 1'b1;
    end else if (mode_r == mode_wake && woken_r) begin
      lin_receive_output <= 1'b0;
    end else if (mode_r == mode_normal || mode_r == mode_rx_only) begin
      lin_receive_output <= rx_filt_r;
    end else begin
      lin_receive_output <= 1'b1;
    end
  end

  // wake indication, one cycle per wake taken
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= wk_out_valid && !woken_r && mode_r == mode_wake;
    end
  end

  // mode status register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_status <= 2'h0;
    end else begin
      mode_status <= mode_r;
    end
  end
endmodule

// File: tb/lin_mode_ctrl_properties.sv
// checker on the ports of the lin mode control block
`timescale 1ns/10ps
module lin_mode_ctrl_checker import lin_mode_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire lin_mode_pkg::chip_mode_type chip_mode,
  input wire logic [1:0] lin_mode_field,
  input wire logic mode_write,
  input wire logic spi_cs_n,
  input wire logic fault_clear,
  input wire logic lin_transmit_input,
  input wire logic bus_level,
  input wire logic bus_drive_dominant,
  input wire logic lin_receive_output,
  input wire logic lin_fault_flag,
  input wire logic wake_event,
  input wire logic [1:0] mode_status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  // mode and output relations
  property p_start_off;
    $fell(reset) |-> mode_status == mode_off && lin_receive_output && !bus_drive_dominant;
  endproperty
  a_start_off: assert property (p_start_off) else $error("not off after reset");
  property p_off_quiet;
    (mode_status == mode_off)[*3] |-> !bus_drive_dominant && !wake_event;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("activity in off mode");
  property p_rx_only_quiet;
    (mode_status == mode_rx_only)[*3] |-> !bus_drive_dominant;
  endproperty
  a_rx_only_quiet: assert property (p_rx_only_quiet) else $error("drive in receive-only");
  property p_chip_gate;
    (chip_mode inside {chip_sleep, chip_restart, chip_fail_safe})[*6] |-> mode_status inside {mode_off, mode_wake};
  endproperty
  a_chip_gate: assert property (p_chip_gate) else $error("active mode in wrong chip mode");
  property p_fail_safe;
    mode_status == mode_normal && chip_mode == chip_fail_safe |-> ##[1:6] mode_status == mode_wake;
  endproperty
  a_fail_safe: assert property (p_fail_safe) else $error("fail-safe did not force wake");
  property p_cs_hold;
    $changed(mode_status) && chip_mode inside {chip_normal, chip_stop}
      |-> $past(spi_cs_n, 1) && $past(spi_cs_n, 2) && $past(spi_cs_n, 3) && $past(spi_cs_n, 4);
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("mode moved without frame end");
  property p_rx_follow;
    ((mode_status == mode_normal || mode_status == mode_rx_only) && $stable(bus_level))[*8]
      |-> lin_receive_output == bus_level;
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("receive not following bus");
  property p_wake_low;
    mode_status == mode_wake && wake_event |-> ##[1:3] !lin_receive_output;
  endproperty
  a_wake_low: assert property (p_wake_low) else $error("receive not low after wake");
  // main scenarios reached
  c_normal: cover property (mode_status == mode_normal && bus_drive_dominant);
  c_wake: cover property (wake_event);
  c_rx_only: cover property (mode_status == mode_rx_only && !lin_receive_output);
endmodule
bind lin_mode_ctrl lin_mode_ctrl_checker u_lin_mode_ctrl_checker (.ref_clk(ref_clk), .reset(reset),
  .chip_mode(chip_mode), .lin_mode_field(lin_mode_field), .mode_write(mode_write), .spi_cs_n(spi_cs_n),
  .fault_clear(fault_clear), .lin_transmit_input(lin_transmit_input), .bus_level(bus_level),
  .bus_drive_dominant(bus_drive_dominant), .lin_receive_output(lin_receive_output),
  .lin_fault_flag(lin_fault_flag), .wake_event(wake_event), .mode_status(mode_status));

// File: tb/lin_mcu_model.sv
// microcontroller model driving the transmit pin
`timescale 1ns/10ps
module lin_mcu_model import lin_mode_pkg::*; (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic early,
  output logic lin_transmit_input
);
  int cnt = 1000;
  // step counter, restarted by go
  always @(posedge ref_clk) begin
    if (go) begin
      cnt <= 0;
    end else if (cnt < 1000) begin
      cnt <= cnt + 1;
    end
  end
  // one dominant bit after the delay; an early low is taken back high in time
  always_comb begin
    lin_transmit_input = !((cnt >= EN_CYCLES + 100 && cnt < EN_CYCLES + 120)
      || (early && cnt >= 50 && cnt < 150));
  end
endmodule

// File: tb/lin_mode_ctrl_test.sv
// testbench for the lin mode control block
`timescale 1ns/10ps
module lin_mode_ctrl_test;
  import lin_mode_pkg::*;
  logic ref_clk = 0;
  logic reset = 1;
  chip_mode_type chip_mode = chip_normal;
  logic [1:0] lin_mode_field = 0;
  logic mode_write = 0;
  logic spi_cs_n = 1;
  logic other_n = 1;
  logic go = 0;
  logic early = 0;
  logic fault_clear = 0;
  wire logic fault;
  wire logic txd;
  wire logic drv;
  wire logic rxd;
  wire logic wake;
  wire logic [1:0] mode_status;
  wire logic bus_level = other_n & ~drv;
  int checks = 0;
  int n_mismatch = 0;
  int d;
  int r;
  int r2;
  always #10 ref_clk = ~ref_clk;
  lin_mode_ctrl u_lin_mode_ctrl (.ref_clk(ref_clk), .reset(reset), .chip_mode(chip_mode),
    .lin_mode_field(lin_mode_field), .mode_write(mode_write), .spi_cs_n(spi_cs_n), .fault_clear(fault_clear),
    .lin_transmit_input(txd), .bus_level(bus_level), .bus_drive_dominant(drv), .lin_receive_output(rxd),
    .lin_fault_flag(fault), .wake_event(wake), .mode_status(mode_status));
  lin_mcu_model u_lin_mcu_model (.ref_clk(ref_clk), .go(go), .early(early), .lin_transmit_input(txd));
  ////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic setm(input logic [1:0] m);
    @(negedge ref_clk);
    lin_mode_field = m;
    mode_write = 1;
    spi_cs_n = 0;
    @(negedge ref_clk);
    mode_write = 0;
    @(negedge ref_clk);
    spi_cs_n = 1;
    repeat (8) @(negedge ref_clk);
  endtask
  // counts drive-high and receive-low cycles
  task automatic watch(input int n, output int dc, output int rc);
    dc = 0;
    rc = 0;
    repeat (n) begin
      @(negedge ref_clk);
      dc += drv;
      rc += !rxd;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_off();
    other_n = 0;
    watch(WAKE_FILT_CYCLES + 50, d, r);
    other_n = 1;
    watch(20, d, r2);
    chk(r + r2, 0);
    chk(mode_status, mode_off);
  endtask
  task automatic t_gate();
    chip_mode = chip_sleep;
    setm(mode_normal);
    chk(mode_status, mode_off);
    chip_mode = chip_restart;
    setm(mode_rx_only);
    chk(mode_status, mode_off);
    chip_mode = chip_normal;
  endtask
  task automatic t_normal(input logic e);
    setm(mode_off);
    setm(mode_normal);
    chk(mode_status, mode_normal);
    early = e;
    go = 1;
    @(negedge ref_clk);
    go = 0;
    watch(EN_CYCLES + 200, d, r);
    chk(d, 20);
    chk(r, 20);
    fault_clear = 1;
    @(negedge ref_clk);
    fault_clear = 0;
    chk(fault, 0);
  endtask
  task automatic t_rx_only();
    chip_mode = chip_stop;
    setm(mode_rx_only);
    chk(mode_status, mode_rx_only);
    go = 1;
    @(negedge ref_clk);
    go = 0;
    watch(EN_CYCLES + 200, d, r);
    chk(d, 0);
    other_n = 0;
    watch(10, d, r);
    other_n = 1;
    watch(20, d, r2);
    chk(r + r2, 10);
    chip_mode = chip_normal;
  endtask
  task automatic t_wake();
    setm(mode_wake);
    other_n = 0;
    repeat (WAKE_FILT_CYCLES + 100) @(negedge ref_clk);
    other_n = 1;
    d = 0;
    repeat (20) begin
      @(negedge ref_clk);
      d += wake;
    end
    chk(d, 1);
    chk(rxd, 0);
    chk(mode_status, mode_wake);
    setm(mode_off);
    chk(rxd, 1);
  endtask
  task automatic t_fail_safe();
    setm(mode_normal);
    chip_mode = chip_fail_safe;
    repeat (10) @(negedge ref_clk);
    chk(mode_status, mode_wake);
    chip_mode = chip_normal;
    setm(mode_off);
  endtask
  task automatic t_off_any();
    for (int i = 0; i < 5; i++) begin
      chip_mode = chip_normal;
      setm(mode_rx_only);
      chip_mode = chip_mode_type'(i);
      setm(mode_off);
      chk(mode_status, mode_off);
    end
    chip_mode = chip_normal;
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (6) @(negedge ref_clk);
    reset = 0;
    @(negedge ref_clk);
    chk({drv, rxd, wake, mode_status}, 5'h08);
    t_off();
    t_gate();
    t_normal(0);
    t_normal(1);
    t_rx_only();
    t_wake();
    t_fail_safe();
    t_off_any();
    conclude();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end
endmodule
